// ===== rtl/irq_mask_pkg.sv
// Constants, types and register map of the interrupt mask and stamp A block.
// Assumes a 125 MHz core clock and a serial host link that is sampled by it.
package irq_mask_pkg;

  localparam int          ADDR_W            = 7;
  localparam int          DATA_W            = 32;
  localparam int          CMD_BITS          = 8;
  localparam int          FRAME_BITS        = CMD_BITS + DATA_W;
  localparam int          CNT_W             = 6;

  localparam logic [6:0]  OFS_STATUS_PRIMARY = 7'h08;
  localparam logic [6:0]  OFS_STATUS_PORTS   = 7'h09;
  localparam logic [6:0]  OFS_MASK_PRIMARY   = 7'h0C;
  localparam logic [6:0]  OFS_MASK_PIN_PORTS = 7'h0D;
  localparam logic [6:0]  OFS_STAMP_A_UPPER  = 7'h10;
  localparam logic [6:0]  OFS_STAMP_A_LOWER  = 7'h11;

  localparam logic [31:0] MASK_PRIMARY_RST   = 32'h00001FBF;
  localparam logic [31:0] MASK_PIN_PORTS_RST = 32'h43FA1F1A;
  localparam logic [31:0] STAMP_RST          = 32'h00000000;

  // Bits that software may change; all others hold their reset value
  localparam logic [31:0] MASK_PRIMARY_WR    = 32'h00001FBF;
  localparam logic [31:0] MASK_PIN_PORTS_WR  = 32'h01FA1F1A;

  // Primary event and mask bit positions
  localparam int BIT_CTRL_PROTECT  = 12;
  localparam int BIT_TX_CHECKSEQ   = 11;
  localparam int BIT_STAMP_C       = 10;
  localparam int BIT_STAMP_B       = 9;
  localparam int BIT_STAMP_A       = 8;
  localparam int BIT_PHY_EVENT     = 7;
  localparam int BIT_RESET_DONE    = 6;
  localparam int BIT_HEADER_FAULT  = 5;
  localparam int BIT_FRAME_LOSS    = 4;
  localparam int BIT_RX_OVERFLOW   = 3;
  localparam int BIT_TX_UNDERFLOW  = 2;
  localparam int BIT_TX_OVERFLOW   = 1;
  localparam int BIT_TX_PROTOCOL   = 0;

  // Pin mask and port event bit positions
  localparam int BIT_P2_CHECKSEQ   = 24;
  localparam int BIT_P2_GAP        = 23;
  localparam int BIT_P2_STAMP_C    = 22;
  localparam int BIT_P2_STAMP_B    = 21;
  localparam int BIT_P2_STAMP_A    = 20;
  localparam int BIT_P2_PHY        = 19;
  localparam int BIT_P2_RX_AVAIL   = 17;
  localparam int BIT_TX_FIFO_PAR   = 12;
  localparam int BIT_RX_FIFO_PAR   = 11;
  localparam int BIT_SPI_FAULT     = 10;
  localparam int BIT_P1_GAP        = 8;
  localparam int BIT_P1_RX_AVAIL   = 4;
  localparam int BIT_TX_FRAME_FIN  = 3;
  localparam int BIT_LINK_CHANGE   = 1;

  typedef enum logic [2:0] {
    LINK_IDLE = 3'b001,
    LINK_CMD  = 3'b010,
    LINK_DATA = 3'b100
  } link_state_e;

  typedef struct packed {
    logic             write;
    logic [ADDR_W-1:0] addr;
  } link_cmd_s;

endpackage : irq_mask_pkg

// ===== rtl/irq_mask_stamp_a.sv
// Interrupt masking, footer extended-status and transmit stamp A capture.
// Assumes status registers live outside and arrive on the core clock; the
// host link pins are asynchronous and are oversampled by the core clock.
//
// Contract
// RULE1: Control protect mask blocks extended status, OA.
// RULE2: Checksum fault mask blocks interrupt output.
// RULE3: Stamp C/B/A masks block extended status.
// RULE4: PHY event mask blocks extended status.
// RULE5: Bit 6 reads zero; reset done unmaskable.
// RULE6: Header fault mask blocks extended status, OA.
// RULE7: Frame loss mask blocks extended status.
// RULE8: Receive overflow mask blocks extended status.
// RULE9: Transmit underflow mask blocks extended status.
// RULE10: Transmit overflow mask blocks extended status.
// RULE11: Transmit protocol mask blocks interrupt output.
// RULE12: Masks reset to documented all-masked values.
// RULE13: Port 2 checksum mask blocks interrupt.
// RULE14: Port 2 stamp C/B/A masks.
// RULE15: Gap fault masks for ports 2, 1.
// RULE16: Port 2 PHY event mask blocks interrupt.
// RULE17: Receive available masks, generic protocol only.
// RULE18: FIFO parity fault masks, transmit and receive.
// RULE19: Link fault mask, generic protocol only.
// RULE20: Frame finished mask, generic protocol only.
// RULE21: Link change mask blocks interrupt.
// RULE22: Read-only 64-bit stamp A, zero reset.
// RULE23: Event bits clear on host write one.
// RULE24: Interrupt asserts on any unmasked event.
// RULE25: Reserved mask bits keep reset values.
`timescale 1ns/1ps
module irq_mask_stamp_a
  import irq_mask_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RSTN,
  input  wire logic              PROTO_OA,
  input  wire logic [DATA_W-1:0] STATUS_PRIMARY,
  input  wire logic [DATA_W-1:0] STATUS_PORTS,
  input  wire logic [63:0]       STAMP_A_IN,
  input  wire logic              STAMP_A_LOAD,
  input  wire logic              SCLK,
  input  wire logic              CS_N,
  input  wire logic              MOSI,
  output logic                   MISO,
  output logic                   MISO_OE,
  output logic                   IRQ_N,
  output logic                   EXST,
  output logic [DATA_W-1:0]      CLR_PRIMARY,
  output logic [DATA_W-1:0]      CLR_PORTS
);

  logic              rst_meta_reg;
  logic              rst_n;
  logic [2:0]        sclk_reg;
  logic [2:0]        csn_reg;
  logic [1:0]        mosi_reg;
  logic [1:0]        oa_reg;
  logic              sclk_rise;
  logic              sclk_fall;
  logic              frame_on;
  link_state_e       state_reg;
  link_state_e       state_next;
  logic [CNT_W-1:0]  bit_cnt_reg;
  logic [CMD_BITS-1:0] cmd_sh_reg;
  link_cmd_s         cmd_reg;
  logic [DATA_W-1:0] wr_sh_reg;
  logic [DATA_W-1:0] rd_sh_reg;
  logic [DATA_W-1:0] rd_word;
  logic              wr_done;
  logic [DATA_W-1:0] mask_primary_reg;
  logic [DATA_W-1:0] mask_pin_reg;
  logic [63:0]       stamp_a_reg;
  logic [DATA_W-1:0] live_primary;
  logic [DATA_W-1:0] live_ports;
  logic [DATA_W-1:0] open_primary;
  logic [DATA_W-1:0] open_ports;

  // Reset release through two flops so every register leaves reset together
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Link pins are asynchronous; stage 0 is only read by stage 1
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg <= 3'h0;
      csn_reg  <= 3'h7;
      mosi_reg <= 2'h0;
      oa_reg   <= 2'h0;
    end else begin
      sclk_reg <= {sclk_reg[1:0], SCLK};
      csn_reg  <= {csn_reg[1:0], CS_N};
      mosi_reg <= {mosi_reg[0], MOSI};
      oa_reg   <= {oa_reg[0], PROTO_OA};
    end
  end

  assign sclk_rise = sclk_reg[1] & ~sclk_reg[2];
  assign sclk_fall = ~sclk_reg[1] & sclk_reg[2];
  assign frame_on  = ~csn_reg[1];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      LINK_IDLE: begin
        if (frame_on) begin
          state_next = LINK_CMD;
        end
      end
      LINK_CMD: begin
        if (!frame_on) begin
          state_next = LINK_IDLE;
        end else if (sclk_rise && bit_cnt_reg == CNT_W'(CMD_BITS - 1)) begin
          state_next = LINK_DATA;
        end
      end
      LINK_DATA: begin
        if (!frame_on) begin
          state_next = LINK_IDLE;
        end
      end
      default: begin
        state_next = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LINK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bits beyond a full frame are ignored so a long select cannot rewrite
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_reg <= '0;
    end else if (!frame_on) begin
      bit_cnt_reg <= '0;
    end else if (sclk_rise && bit_cnt_reg != CNT_W'(FRAME_BITS)) begin
      bit_cnt_reg <= bit_cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_sh_reg <= '0;
      cmd_reg    <= '0;
    end else if (state_reg == LINK_CMD && sclk_rise) begin
      cmd_sh_reg <= {cmd_sh_reg[CMD_BITS-2:0], mosi_reg[1]};
      if (bit_cnt_reg == CNT_W'(CMD_BITS - 1)) begin
        cmd_reg <= link_cmd_s'({cmd_sh_reg[CMD_BITS-2:0], mosi_reg[1]});
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_sh_reg <= '0;
    end else if (state_reg == LINK_DATA && sclk_rise) begin
      wr_sh_reg <= {wr_sh_reg[DATA_W-2:0], mosi_reg[1]};
    end
  end

  assign wr_done = (state_reg == LINK_DATA) && sclk_rise && cmd_reg.write &&
                   (bit_cnt_reg == CNT_W'(FRAME_BITS - 1));

  // Read word is chosen from the address just received
  always_comb begin
    rd_word = '0;
    case (cmd_reg.addr)
      OFS_MASK_PRIMARY:   rd_word = mask_primary_reg;
      OFS_MASK_PIN_PORTS: rd_word = mask_pin_reg;
      OFS_STAMP_A_UPPER:  rd_word = stamp_a_reg[63:32]; // RULE22
      OFS_STAMP_A_LOWER:  rd_word = stamp_a_reg[31:0]; // RULE22
      OFS_STATUS_PRIMARY: rd_word = STATUS_PRIMARY;
      OFS_STATUS_PORTS:   rd_word = STATUS_PORTS;
      default:            rd_word = '0;
    endcase
  end

  // Word is loaded one cycle after the command lands, well before the next fall
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      rd_sh_reg <= '0;
      MISO      <= 1'b0;
      MISO_OE   <= 1'b0;
    end else begin
      MISO_OE <= frame_on;
      if (!frame_on) begin
        MISO <= 1'b0;
      end else if (state_reg == LINK_CMD && state_next == LINK_DATA) begin
        rd_sh_reg <= '0;
      end else if (state_reg == LINK_DATA && bit_cnt_reg == CNT_W'(CMD_BITS) &&
                   !sclk_fall && rd_sh_reg == '0 && MISO == 1'b0) begin
        rd_sh_reg <= rd_word;
      end else if (state_reg == LINK_DATA && sclk_fall) begin
        MISO      <= rd_sh_reg[DATA_W-1];
        rd_sh_reg <= {rd_sh_reg[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Writable bits take the host word; reserved ones are forced back
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mask_primary_reg <= MASK_PRIMARY_RST; // RULE12
      mask_pin_reg     <= MASK_PIN_PORTS_RST; // RULE12
    end else if (wr_done) begin
      if (cmd_reg.addr == OFS_MASK_PRIMARY) begin
        mask_primary_reg <= ({wr_sh_reg[DATA_W-2:0], mosi_reg[1]} & MASK_PRIMARY_WR) |
                            (MASK_PRIMARY_RST & ~MASK_PRIMARY_WR); // RULE5 RULE25
      end
      if (cmd_reg.addr == OFS_MASK_PIN_PORTS) begin
        mask_pin_reg <= ({wr_sh_reg[DATA_W-2:0], mosi_reg[1]} & MASK_PIN_PORTS_WR) |
                        (MASK_PIN_PORTS_RST & ~MASK_PIN_PORTS_WR); // RULE25
      end
    end
  end

  // Write-one-to-clear strobes for the external status registers
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CLR_PRIMARY <= '0;
      CLR_PORTS   <= '0;
    end else begin
      CLR_PRIMARY <= (wr_done && cmd_reg.addr == OFS_STATUS_PRIMARY) ?
                     {wr_sh_reg[DATA_W-2:0], mosi_reg[1]} : '0; // RULE23
      CLR_PORTS   <= (wr_done && cmd_reg.addr == OFS_STATUS_PORTS) ?
                     {wr_sh_reg[DATA_W-2:0], mosi_reg[1]} : '0; // RULE23
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      stamp_a_reg <= {STAMP_RST, STAMP_RST};
    end else if (STAMP_A_LOAD) begin
      stamp_a_reg <= STAMP_A_IN; // RULE22
    end
  end

  // Protocol-specific events are dropped when the other protocol is active
  always_comb begin
    live_primary = STATUS_PRIMARY;
    live_ports   = STATUS_PORTS;
    live_primary[BIT_RESET_DONE] = 1'b0;
    if (oa_reg[1]) begin
      live_ports[BIT_P2_RX_AVAIL]  = 1'b0; // RULE17
      live_ports[BIT_P1_RX_AVAIL]  = 1'b0; // RULE17
      live_ports[BIT_SPI_FAULT]    = 1'b0; // RULE19
      live_ports[BIT_TX_FRAME_FIN] = 1'b0; // RULE20
    end else begin
      live_primary[BIT_CTRL_PROTECT] = 1'b0; // RULE1
      live_primary[BIT_HEADER_FAULT] = 1'b0; // RULE6
    end
  end

  // One gate per bit; the mask layout places each mask over its event
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_gate
      // RULE1 RULE2 RULE3 RULE4 RULE6 RULE7 RULE8 RULE9 RULE10 RULE11
      assign open_primary[gi] = live_primary[gi] & ~mask_primary_reg[gi];
      // RULE13 RULE14 RULE15 RULE16 RULE17 RULE18 RULE19 RULE20 RULE21
      assign open_ports[gi]   = live_ports[gi] & ~mask_pin_reg[gi];
    end
  endgenerate

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ_N <= 1'b1;
      EXST  <= 1'b0;
    end else begin
      IRQ_N <= ~(STATUS_PRIMARY[BIT_RESET_DONE] | (|open_primary) |
                 (|open_ports)); // RULE5 RULE24
      EXST  <= STATUS_PRIMARY[BIT_RESET_DONE] | (|open_primary);
    end
  end

endmodule : irq_mask_stamp_a

// ===== verification/spi_host_model.sv
// Behavioural host on the serial register link, mode 0, MSB first.
// Assumes a 40-bit frame: write flag, 7-bit address, 32 data bits.
`timescale 1ns/1ps
module spi_host_model
  import irq_mask_pkg::*;
(
  output logic              sclk,
  output logic              cs_n,
  output logic              mosi,
  input  wire logic         miso,
  output logic              rd_done,
  output logic [DATA_W-1:0] rd_data
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rd_done = 1'b0;
    rd_data = 32'h00000000;
  end

  // Clear bits are requested by writing ones to the status offsets
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [31:0] wdata);
    logic [39:0] frame;
    frame = {wr, addr, wdata};
    cs_n = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      mosi = frame[i];
      #40 sclk = 1'b1;
      if (i < 32) rd_data[i] = miso;
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // Deselected line must not look like stable data
    mosi = ~mosi;
    rd_done = !wr;
    #80 rd_done = 1'b0;
  endtask : xfer
endmodule : spi_host_model

// ===== verification/irq_mask_stamp_a_sva.sv
// Pin-level checker for irq_mask_stamp_a, bound to its ports.
// Masks are internal, so relations lean on status inputs only.
`timescale 1ns/1ps
module irq_mask_stamp_a_sva
  import irq_mask_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RSTN,
  input wire logic              CS_N,
  input wire logic              MISO_OE,
  input wire logic [DATA_W-1:0] STATUS_PRIMARY,
  input wire logic [DATA_W-1:0] STATUS_PORTS,
  input wire logic              IRQ_N,
  input wire logic              EXST,
  input wire logic [DATA_W-1:0] CLR_PRIMARY,
  input wire logic [DATA_W-1:0] CLR_PORTS
);
  // Outputs are trusted only once the reset synchroniser has let go
  logic [3:0] up_reg;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) up_reg <= 4'h0;
    else up_reg <= {up_reg[2:0], 1'b1};
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  a_done_pulls_irq: assert property (up_reg[3] && STATUS_PRIMARY[BIT_RESET_DONE] |=> !IRQ_N)
    else $error("reset done left irq high");
  a_done_sets_exst: assert property (up_reg[3] && STATUS_PRIMARY[BIT_RESET_DONE] |=> EXST)
    else $error("reset done left exst low");
  a_quiet_irq_high: assert property (up_reg[3] && !(|{STATUS_PRIMARY, STATUS_PORTS}) |=> IRQ_N)
    else $error("irq low with no event");
  a_quiet_exst_low: assert property (up_reg[3] && !(|STATUS_PRIMARY) |=> !EXST)
    else $error("exst set with no primary event");
  a_exst_with_irq: assert property (EXST |-> !IRQ_N)
    else $error("exst without irq");
  a_irq_has_cause: assert property (up_reg[3] && !IRQ_N |-> $past(|{STATUS_PRIMARY, STATUS_PORTS}))
    else $error("irq low without cause");
  a_clr_one_cycle: assert property (|CLR_PRIMARY |=> !(|CLR_PRIMARY) ##1 !(|CLR_PRIMARY))
    else $error("primary clear not a pulse");
  a_clr_ports_alone: assert property (|CLR_PORTS |-> !(|CLR_PRIMARY) ##1 !(|CLR_PORTS))
    else $error("ports clear not a lone pulse");
  // Enable lags the deselect by the two-flop pin stage plus its own flop
  a_oe_drops_late: assert property (up_reg[3] && $rose(CS_N) |-> ##[1:4] !MISO_OE)
    else $error("miso enable kept after deselect");
endmodule : irq_mask_stamp_a_sva

bind irq_mask_stamp_a irq_mask_stamp_a_sva chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
  .CS_N(CS_N), .MISO_OE(MISO_OE),
  .STATUS_PRIMARY(STATUS_PRIMARY), .STATUS_PORTS(STATUS_PORTS), .IRQ_N(IRQ_N),
  .EXST(EXST), .CLR_PRIMARY(CLR_PRIMARY), .CLR_PORTS(CLR_PORTS));

// ===== verification/irq_mask_stamp_a_bench.sv
// Self-checking bench: register reads, mask gating and clear pulses.
// Assumes the host model drives the link and the checker is bound in.
`timescale 1ns/1ps
module irq_mask_stamp_a_bench;
  import irq_mask_pkg::*;
  logic              CORE_CLK = 1'b0;
  logic              RSTN, PROTO_OA, STAMP_A_LOAD, SCLK, CS_N, MOSI;
  logic              MISO, MISO_OE, IRQ_N, EXST, rd_done;
  logic [DATA_W-1:0] STATUS_PRIMARY, STATUS_PORTS, CLR_PRIMARY, CLR_PORTS, rd_data;
  logic [63:0]       STAMP_A_IN;
  logic [31:0]       wq[$];
  logic [1:0]        pq[$];
  int                num_errors = 0;
  int                compares = 0;
  event              pin_ev;

  always #4 CORE_CLK = ~CORE_CLK;

  irq_mask_stamp_a dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .PROTO_OA(PROTO_OA),
    .STATUS_PRIMARY(STATUS_PRIMARY), .STATUS_PORTS(STATUS_PORTS), .STAMP_A_IN(STAMP_A_IN),
    .STAMP_A_LOAD(STAMP_A_LOAD), .SCLK(SCLK), .CS_N(CS_N), .MOSI(MOSI), .MISO(MISO),
    .MISO_OE(MISO_OE), .IRQ_N(IRQ_N), .EXST(EXST), .CLR_PRIMARY(CLR_PRIMARY),
    .CLR_PORTS(CLR_PORTS));
  spi_host_model host (.sclk(SCLK), .cs_n(CS_N), .mosi(MOSI), .miso(MISO),
    .rd_done(rd_done), .rd_data(rd_data));

  task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_word

  task automatic cmp_pins(input logic [1:0] exp, input logic [1:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_pins

  always @(posedge rd_done) cmp_word(wq.pop_front(), rd_data);
  // Clear pulses launch on the rising edge, so they are looked at on the falling one
  always @(negedge CORE_CLK) begin
    if (|{CLR_PRIMARY, CLR_PORTS}) cmp_word(wq.pop_front(), CLR_PRIMARY | CLR_PORTS);
  end
  always @(pin_ev) cmp_pins(pq.pop_front(), {IRQ_N, EXST});

  task automatic rd(input logic [6:0] a, input logic [31:0] e);
    wq.push_back(e);
    host.xfer(1'b0, a, 32'h00000000);
    @(negedge CORE_CLK);
  endtask : rd

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
    @(negedge CORE_CLK);
  endtask : wr

  // Pins follow status within three cycles, six leaves margin
  task automatic pins(input logic [1:0] e);
    repeat (6) @(negedge CORE_CLK);
    pq.push_back(e);
    -> pin_ev;
  endtask : pins

  task automatic test_done();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  initial begin
    #800000;
    num_errors++;
    test_done();
  end

  initial begin
    logic [31:0] v;
    logic [63:0] s;
    bit          act;
    RSTN = 1'b0;
    PROTO_OA = 1'b1;
    STATUS_PRIMARY = 32'h00000000;
    STATUS_PORTS = 32'h00000000;
    STAMP_A_IN = 64'h0000000000000000;
    STAMP_A_LOAD = 1'b0;
    void'($urandom(92824));
    repeat (4) @(negedge CORE_CLK);
    RSTN = 1'b1;
    repeat (6) @(negedge CORE_CLK);
    rd(OFS_MASK_PRIMARY, MASK_PRIMARY_RST);
    rd(OFS_MASK_PIN_PORTS, MASK_PIN_PORTS_RST);
    rd(OFS_STAMP_A_UPPER, STAMP_RST);
    rd(7'h7F, 32'h00000000);
    STATUS_PRIMARY = MASK_PRIMARY_RST;
    STATUS_PORTS = MASK_PIN_PORTS_WR;
    pins(2'b10);
    STATUS_PRIMARY[BIT_RESET_DONE] = 1'b1;
    pins(2'b01);
    repeat (3) begin
      v = $urandom();
      wr(OFS_MASK_PRIMARY, v);
      rd(OFS_MASK_PRIMARY, v & MASK_PRIMARY_WR);
      wr(OFS_MASK_PIN_PORTS, v);
      rd(OFS_MASK_PIN_PORTS, (v & MASK_PIN_PORTS_WR) | (MASK_PIN_PORTS_RST & ~MASK_PIN_PORTS_WR));
    end
    wr(OFS_STAMP_A_LOWER, 32'hFFFFFFFF);
    rd(OFS_STAMP_A_LOWER, STAMP_RST);
    s = {$urandom(), $urandom()};
    STAMP_A_IN = s;
    STAMP_A_LOAD = 1'b1;
    @(negedge CORE_CLK);
    STAMP_A_LOAD = 1'b0;
    STAMP_A_IN = ~s;
    rd(OFS_STAMP_A_UPPER, s[63:32]);
    rd(OFS_STAMP_A_LOWER, s[31:0]);
    v = ($urandom() & MASK_PRIMARY_WR) | 32'h00000002;
    wq.push_back(v);
    wr(OFS_STATUS_PRIMARY, v);
    v = ($urandom() & MASK_PIN_PORTS_WR) | 32'h00000002;
    wq.push_back(v);
    wr(OFS_STATUS_PORTS, v);
    STATUS_PRIMARY = 32'h00000000;
    STATUS_PORTS = 32'h00000000;
    for (int p = 0; p < 2; p++) begin
      PROTO_OA = p[0];
      for (int r = 0; r < 2; r++) begin
        for (int b = 0; b < 25; b++) begin
          v = 32'h00000001 << b;
          if ((v & (r ? MASK_PIN_PORTS_WR & ~32'h00000200 : MASK_PRIMARY_WR)) == 0) continue;
          wr(r ? OFS_MASK_PIN_PORTS : OFS_MASK_PRIMARY, 32'h00000000);
          act = r ? !(p == 1 && b inside {17, 10, 4, 3}) : !(p == 0 && b inside {12, 5});
          if (r) STATUS_PORTS = v;
          else STATUS_PRIMARY = v;
          pins({!act, act && r == 0});
          wr(r ? OFS_MASK_PIN_PORTS : OFS_MASK_PRIMARY, v);
          pins(2'b10);
          STATUS_PRIMARY = 32'h00000000;
          STATUS_PORTS = 32'h00000000;
        end
      end
    end
    RSTN = 1'b0;
    repeat (2) @(negedge CORE_CLK);
    RSTN = 1'b1;
    repeat (6) @(negedge CORE_CLK);
    rd(OFS_MASK_PIN_PORTS, MASK_PIN_PORTS_RST);
    repeat (10) @(negedge CORE_CLK);
    test_done();
  end
endmodule : irq_mask_stamp_a_bench
